// file: baud_gen.sv
/*
  Shared bit-time tick generator: one tick every divider clocks while running.
  Assumes the divider is not changed mid-frame; fractional modulation lives elsewhere.
*/
`timescale 1ns/1ps
module baud_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic [uart_tx_pkg::BAUD_W-1:0] divider,
  // tick out
  output logic tick
);
  import uart_tx_pkg::*;

  logic [BAUD_W-1:0] cnt_r;

  // tick on the last clock of each bit time
  assign tick = run & (cnt_r == BAUD_W'(divider - 1'b1));

  // counter restarts whenever the port is off so the first bit is full length
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= '0;
    else if (clk_en) cnt_r <= (!run || tick) ? '0 : BAUD_W'(cnt_r + 1'b1);
  end
endmodule // baud_gen

// file: serial_peer.sv
/*
  Remote serial device model: decodes the frames seen on the transmit wire.
  Assumes the bench hands it the bit time in clocks and the word length in use.
*/
`timescale 1ns/1ps
module serial_peer (
  // clock and line
  input wire logic ref_clk,
  input wire logic sd,
  // format known to the far side
  input wire logic [15:0] div,
  input wire logic [3:0] nbits,
  // decoded result
  output logic [8:0] word,
  output logic stop_ok,
  output int frames,
  // far side transmit line, a pulled-up wire that it never pulls low here
  output logic peer_tx
);
  // one frame per loop; samples near mid-bit so a one-cycle skew is harmless
  initial begin
    logic [8:0] w;
    logic s;
    frames = 0;
    word = 9'h000;
    stop_ok = 1'h0;
    peer_tx = 1'h1;
    forever begin
      // low level after idle marks the start bit
      @(posedge ref_clk iff sd === 1'h0);
      repeat (div / 2) @(posedge ref_clk);
      w = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (div) @(posedge ref_clk);
        w[i] = sd;
      end
      // both stop bits must read high
      repeat (div) @(posedge ref_clk);
      s = sd;
      repeat (div) @(posedge ref_clk);
      s = s & sd;
      // publish whole frames only, so a back-to-back frame cannot wipe the result early
      word = w;
      stop_ok = s;
      frames++;
    end
  end
endmodule // serial_peer

// file: tb_top.sv
/*
  Self-checking bench for the serial port transmit path and its enables.
  Assumes the design package, the design modules and serial_peer are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import uart_tx_pkg::*;
  // format rows: {nine, parity on, parity type, ninth bit}, byte, word seen by the peer
  localparam logic [21:0] rows [8] = '{
    {5'h00, 8'hA5, 9'h0A5}, {5'h08, 8'hA5, 9'h0A5}, {5'h0A, 8'hA5, 9'h025},
    {5'h0C, 8'h25, 9'h0A5}, {5'h0E, 8'hA5, 9'h025}, {5'h11, 8'h5A, 9'h15A},
    {5'h19, 8'hA5, 9'h0A5}, {5'h1A, 8'hA5, 9'h1A5}};
  // stimulus
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic clk_en = 1'h1;
  logic ctrl_wr = 1'h0;
  logic [7:0] cw = 8'h00; // serial, tx, rx, nine, parity on, parity type, ninth bit
  logic status_rd = 1'h0;
  logic data_wr = 1'h0;
  logic [7:0] data_in = 8'h00;
  logic rx_busy = 1'h0;
  logic [3:0] nb = 4'h8;
  // observed
  logic serial_enable_bit, transmit_enable_bit, receive_enable_bit, break_send_bit;
  logic word_length_select, parity_enable_bit, receive_stop_count_select;
  logic transmit_ninth_bit, address_detect_enable, transmit_empty_flag, transmit_idle_flag;
  logic receive_idle_flag, rx_flags_clear, baud_tick, rx_line, rx_line_en;
  logic serial_output_pin, serial_output_oe, peer_tx, stop_ok;
  logic [1:0] parity_type_select;
  logic [15:0] baud_divider;
  logic [8:0] word;
  int frames;
  int nf = 0, failures = 0, checks = 0, ticks = 0;
  // a released output pin is pulled high
  wire logic tx_wire = serial_output_oe ? serial_output_pin : 1'h1;

  uart_format_enable_transmitter uart_format_enable_transmitter_i (
    .ref_clk, .reset_n, .clk_en, .ctrl_wr,
    .wr_serial_enable(cw[7]), .wr_transmit_enable(cw[6]), .wr_receive_enable(cw[5]),
    .wr_break_send(1'h0), .wr_word_length_select(cw[4]), .wr_parity_enable_bit(cw[3]),
    .wr_parity_type_select(cw[2:1]), .wr_receive_stop_count_select(1'h1),
    .wr_transmit_ninth_bit(cw[0]), .wr_address_detect_enable(1'h0),
    .wr_baud_divider(16'h0004), .status_rd, .data_wr, .data_in, .serial_enable_bit,
    .transmit_enable_bit, .receive_enable_bit, .break_send_bit, .word_length_select,
    .parity_enable_bit, .parity_type_select, .receive_stop_count_select, .transmit_ninth_bit,
    .address_detect_enable, .baud_divider, .transmit_empty_flag, .transmit_idle_flag,
    .receive_idle_flag, .rx_busy, .rx_flags_clear, .baud_tick, .rx_line, .rx_line_en,
    .serial_output_pin, .serial_output_oe, .serial_input_pin(peer_tx));

  serial_peer serial_peer_i (.ref_clk, .sd(tx_wire), .div(16'h0004), .nbits(nb), .word,
    .stop_ok, .frames, .peer_tx);

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // shared bit-time pulses counted as the design makes them
  always @(posedge ref_clk) begin
    if (baud_tick === 1'h1) ticks++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // whole control word in one strobe
  task automatic ctrl(input logic [7:0] v);
    @(posedge ref_clk);
    ctrl_wr <= 1'h1;
    cw <= v;
    @(posedge ref_clk);
    ctrl_wr <= 1'h0;
  endtask

  // status read arms the write; arm low leaves the write unarmed
  task automatic send(input logic [7:0] d, input logic arm);
    @(posedge ref_clk);
    status_rd <= arm;
    @(posedge ref_clk);
    status_rd <= 1'h0;
    data_wr <= 1'h1;
    data_in <= d;
    @(posedge ref_clk);
    data_wr <= 1'h0;
  endtask

  // bounded wait for the peer, then let the frame tail and idle flag land
  task automatic wait_frames(input int n);
    for (int i = 0; i < 300 && frames < n; i++) @(posedge ref_clk);
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge ref_clk);
    chk(16'(frames), 16'(nf));
  endtask

  task automatic close_out();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog well beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(negedge ref_clk);
    chk({word_length_select, parity_enable_bit, receive_stop_count_select}, 3'h0);
    chk({transmit_empty_flag, transmit_idle_flag, serial_output_pin, serial_output_oe}, 4'hE);
    chk(baud_divider, 16'h0010);
    $display("test reset done");
    // every parity code and both word lengths
    foreach (rows[k]) begin
      nb <= rows[k][21] ? 4'h9 : 4'h8;
      ctrl({3'h7, rows[k][21:17]});
      send(rows[k][16:9], 1'h1);
      repeat (2) @(negedge ref_clk);
      chk(transmit_idle_flag, 1'h0);
      nf++;
      wait_frames(nf);
      chk(word, 16'(rows[k][8:0]));
      chk({stop_ok, transmit_idle_flag}, 2'h3);
    end
    $display("test format rows done");
    nb <= 4'h8;
    ctrl(8'hA0);
    send(8'hC3, 1'h1);
    quiet(150);
    ctrl(8'hE0);
    nf++;
    wait_frames(nf);
    chk(word, 9'h0C3);
    // back to back words, then an unarmed write
    send(8'h11, 1'h1);
    send(8'h22, 1'h1);
    send(8'h33, 1'h0);
    wait_frames(nf + 1);
    chk({stop_ok, word}, 10'h211);
    nf = nf + 2;
    wait_frames(nf);
    chk({stop_ok, word}, 10'h222);
    quiet(150);
    $display("test order done");
    // fill the buffer, then disable the port
    ctrl(8'hB3);
    for (int i = 0; i < 16; i++) send(8'(i), 1'h1);
    @(negedge ref_clk);
    chk(transmit_empty_flag, 1'h0);
    ctrl(8'h33);
    repeat (2) @(negedge ref_clk);
    chk({transmit_enable_bit, receive_enable_bit, break_send_bit, rx_flags_clear}, 4'h1);
    chk({transmit_empty_flag, transmit_idle_flag, serial_output_oe}, 3'h6);
    chk({word_length_select, parity_type_select, transmit_ninth_bit}, 4'hB);
    chk(baud_divider, 16'h0004);
    send(8'h44, 1'h1);
    ctrl(8'hE0);
    quiet(200);
    chk(serial_output_pin, 1'h1);
    $display("test disable done");
    send(8'h0F, 1'h1);
    repeat (30) @(posedge ref_clk);
    ctrl(8'hA0);
    repeat (2) @(negedge ref_clk);
    chk({serial_output_oe, serial_output_pin}, 2'h1);
    ctrl(8'hE0);
    send(8'hF0, 1'h1);
    repeat (30) @(posedge ref_clk);
    ctrl(8'h00);
    repeat (2) @(negedge ref_clk);
    chk({serial_output_oe, serial_output_pin, transmit_idle_flag}, 3'h3);
    repeat (100) @(posedge ref_clk);
    nf = frames;
    $display("test abort done");
    // receive pin ownership and the shared bit clock
    ctrl(8'hA0);
    rx_busy <= 1'h1;
    repeat (3) @(negedge ref_clk);
    chk({receive_idle_flag, rx_line_en, rx_line, serial_output_oe}, 4'h6);
    ticks = 0;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(ticks), 16'h000A);
    ctrl(8'h80);
    repeat (2) @(negedge ref_clk);
    chk({receive_idle_flag, rx_line_en}, 2'h2);
    // enable low must freeze the control registers against a write
    @(posedge ref_clk);
    rx_busy <= 1'h0;
    clk_en <= 1'h0;
    ctrl(8'h00);
    repeat (2) @(negedge ref_clk);
    chk({serial_enable_bit, receive_enable_bit}, 2'h2);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    $display("test receive side done");
    close_out();
  end
endmodule // tb_top

// file: tx_fifo.sv
/*
  Word FIFO with registered read data, valid/ready on both sides and a flush.
  Assumes DEPTH is a power of two and a single clock with a clock enable.
*/
`timescale 1ns/1ps
module tx_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_r;
  logic [W-1:0] out_data_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // handshake decode
  assign in_ready = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
  assign out_data = out_data_r;

  // storage array, no reset needed
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and registered head word; bypass covers a write to the next head slot
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      out_data_r <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        count_r <= '0;
      end else begin
        if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
        rd_ptr_r <= rd_ptr_nxt;
        if (push && !pop) count_r <= count_r + 1'b1;
        else if (pop && !push) count_r <= count_r - 1'b1;
        out_data_r <= (push && wr_ptr_r == rd_ptr_nxt) ? in_data : mem[rd_ptr_nxt];
      end
    end
  end
endmodule // tx_fifo

// file: uart_format_enable_transmitter.sv
/*
  Serial port format, enable/disable control and transmit path with a 16-word buffer.
  Assumes software strobes are single-cycle on ref_clk; the receiver sits outside and
  uses the shared baud tick, the synchronised input line and the flag clear level.
*/
// Operation
// - frame is NRZ: one start bit, eight or nine data bits, stop bits.
// - parity may be even, odd, mark, space or off.
// - after reset the format is eight data bits, no parity, one stop bit.
// - transmitter always sends two stop bits; receiver stop count is selectable.
// - bits go out and come in least significant bit first.
// - transmit and receive share one 16-bit baud generator and format.
// - pins serve the port only while serial and path enables are set.
// - output pin idles high when no frame is in flight.
// - clearing serial enable empties the buffer and releases both pins.
// - disabling clears enables, break and receive flags; sets empty and idle flags.
// - disabling keeps all other configuration so re-enable resumes unchanged.
// - disabling mid-activity stops all transfers at once.
// - word length select picks nine bits, ninth from transmit ninth bit.
// - with address detection the word MSB is the address bit.
// - shift register reloads only after the previous stop bits are sent.
// - transmission starts once enable is set and data waits, either order.
// - a word written while the shifter is empty moves straight into it.
// - clearing transmit enable stops shifting, resets transmitter, frees pin.
// - writes to the data buffer are blocked while the empty flag is low.
// - the shift register is internal and cannot be read or written.
// - empty flag rises when the buffer can take another word.
// - idle flag sets when a frame ends; status-read then write clears it.
`timescale 1ns/1ps
module uart_format_enable_transmitter (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // control write
  input wire logic ctrl_wr,
  input wire logic wr_serial_enable,
  input wire logic wr_transmit_enable,
  input wire logic wr_receive_enable,
  input wire logic wr_break_send,
  input wire logic wr_word_length_select,
  input wire logic wr_parity_enable_bit,
  input wire logic [1:0] wr_parity_type_select,
  input wire logic wr_receive_stop_count_select,
  input wire logic wr_transmit_ninth_bit,
  input wire logic wr_address_detect_enable,
  input wire logic [uart_tx_pkg::BAUD_W-1:0] wr_baud_divider,
  // software data access
  input wire logic status_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_in,
  // control and status readback
  output logic serial_enable_bit,
  output logic transmit_enable_bit,
  output logic receive_enable_bit,
  output logic break_send_bit,
  output logic word_length_select,
  output logic parity_enable_bit,
  output logic [1:0] parity_type_select,
  output logic receive_stop_count_select,
  output logic transmit_ninth_bit,
  output logic address_detect_enable,
  output logic [uart_tx_pkg::BAUD_W-1:0] baud_divider,
  output logic transmit_empty_flag,
  output logic transmit_idle_flag,
  output logic receive_idle_flag,
  // receiver side
  input wire logic rx_busy,
  output logic rx_flags_clear,
  output logic baud_tick,
  output logic rx_line,
  output logic rx_line_en,
  // serial pins
  output logic serial_output_pin,
  output logic serial_output_oe,
  input wire logic serial_input_pin
);
  import uart_tx_pkg::*;

  // control registers
  logic serial_r;
  logic tx_en_r;
  logic rx_en_r;
  logic brk_r;
  logic word_len_r;
  logic par_en_r;
  logic [1:0] par_type_r;
  logic rx_stop_r;
  logic ninth_r;
  logic addr_det_r;
  logic [BAUD_W-1:0] div_r;

  // transmit state
  tx_state_e state_r;
  tx_state_e state_nxt;
  logic [FRAME_W-1:0] shift_r;
  logic [FRAME_W-1:0] shift_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] frame_len_r;
  logic idle_r;
  logic arm_r;
  logic [1:0] rx_sync_r;

  // buffer ports
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_word;

  // parity of the covered bits for the selected type
  // four parity types; parity off is handled by the caller
  function automatic logic parity_of(input logic [WORD_W-1:0] bits, input logic [1:0] pt);
    logic p;
    p = 1'b0;
    unique case (pt)
      PAR_EVEN: p = ^bits;
      PAR_ODD: p = ~^bits;
      PAR_MARK: p = 1'b1;
      PAR_SPACE: p = 1'b0;
    endcase
    return p;
  endfunction

  // whole frame, LSB goes out first; the parity slot overwrites the word MSB
  // start, word, stops
  function automatic logic [FRAME_W-1:0] make_frame(input logic [WORD_W-1:0] w,
      input logic nine, input logic par_on, input logic [1:0] pt);
    logic [WORD_W-1:0] p;
    p = w;
    if (par_on && nine) p[MSB_9] = parity_of(w & MASK_BELOW_9, pt);
    if (par_on && !nine) p[MSB_8] = parity_of(w & MASK_BELOW_8, pt);
    if (nine) return {STOP_PAIR, p, START_LVL};
    return {IDLE_LVL, STOP_PAIR, p[MSB_8:0], START_LVL};
  endfunction

  // path decode
  // pin ownership
  wire tx_path_on = serial_r & tx_en_r;
  wire par_active = par_en_r & ~addr_det_r;
  wire in_shift = (state_r == TX_SHIFT);
  wire last_bit = in_shift & (bit_cnt_r == 4'(frame_len_r - BIT_STEP));
  wire load_go = baud_tick & tx_path_on & fifo_out_valid & (~in_shift | last_bit);
  wire frame_done = baud_tick & tx_path_on & last_bit;
  wire wr_accept = data_wr & arm_r & fifo_in_ready & serial_r;
  wire [FRAME_W-1:0] frame_new = make_frame(fifo_word, word_len_r, par_active, par_type_r);

  // readback and side outputs
  assign serial_enable_bit = serial_r;
  assign transmit_enable_bit = tx_en_r;
  assign receive_enable_bit = rx_en_r;
  assign break_send_bit = brk_r;
  assign word_length_select = word_len_r;
  assign parity_enable_bit = par_en_r;
  assign parity_type_select = par_type_r;
  assign receive_stop_count_select = rx_stop_r;
  assign transmit_ninth_bit = ninth_r;
  assign address_detect_enable = addr_det_r;
  assign baud_divider = div_r;
  // empty means room for one more word
  assign transmit_empty_flag = fifo_in_ready;
  assign transmit_idle_flag = idle_r;
  // receive flags and count cleared while off
  assign rx_flags_clear = ~serial_r;
  assign receive_idle_flag = ~(rx_busy & rx_line_en);
  assign rx_line_en = serial_r & rx_en_r;
  assign rx_line = rx_sync_r[1];
  // pin freed when transmit enable drops
  assign serial_output_oe = tx_path_on;
  // idle level comes from the all-ones shifter
  assign serial_output_pin = shift_r[0];

  baud_gen u_baud (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(serial_r),
    .divider(div_r),
    .tick(baud_tick)
  );

  // software words wait here; ninth bit captured with the byte
  // disable empties buffer
  tx_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .flush(~serial_r),
    .in_valid(wr_accept),
    .in_ready(fifo_in_ready),
    .in_data({ninth_r, data_in}),
    .out_valid(fifo_out_valid),
    .out_ready(load_go),
    .out_data(fifo_word)
  );

  // input pin synchroniser; only the second stage is read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rx_sync_r <= {IDLE_LVL, IDLE_LVL};
    else if (clk_en) rx_sync_r <= {rx_sync_r[0], serial_input_pin};
  end

  // control register writes; path enables can only stand with serial enable
  // power-on format
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_r <= 1'b0;
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      brk_r <= 1'b0;
      word_len_r <= RST_WORD_LEN;
      par_en_r <= RST_PARITY_EN;
      par_type_r <= RST_PARITY_TYPE;
      rx_stop_r <= RST_RX_STOP;
      ninth_r <= 1'b0;
      addr_det_r <= 1'b0;
      div_r <= RST_BAUD_DIV;
    end else if (clk_en && ctrl_wr) begin
      serial_r <= wr_serial_enable;
      tx_en_r <= wr_serial_enable & wr_transmit_enable;
      rx_en_r <= wr_serial_enable & wr_receive_enable;
      brk_r <= wr_serial_enable & wr_break_send;
      word_len_r <= wr_word_length_select;
      par_en_r <= wr_parity_enable_bit;
      par_type_r <= wr_parity_type_select;
      rx_stop_r <= wr_receive_stop_count_select;
      ninth_r <= wr_transmit_ninth_bit;
      addr_det_r <= wr_address_detect_enable;
      div_r <= wr_baud_divider;
    end
  end

  // next state of the shifter
  // disable stops at once
  // empty shifter takes word on next tick
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    if (!tx_path_on) begin
      state_nxt = TX_IDLE;
      shift_nxt = FRAME_IDLE;
    end else if (load_go) begin
      state_nxt = TX_SHIFT;
      shift_nxt = frame_new;
    end else if (baud_tick && in_shift) begin
      shift_nxt = {IDLE_LVL, shift_r[FRAME_W-1:1]};
      if (last_bit) state_nxt = TX_IDLE;
    end
  end

  // transmit shifter, kept internal with no software access
  // no readback path
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= TX_IDLE;
      shift_r <= FRAME_IDLE;
      bit_cnt_r <= '0;
      frame_len_r <= FRAME_LEN_8;
    end else if (clk_en) begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      if (load_go) begin
        bit_cnt_r <= '0;
        frame_len_r <= word_len_r ? FRAME_LEN_9 : FRAME_LEN_8;
      end else if (baud_tick && in_shift) begin
        bit_cnt_r <= 4'(bit_cnt_r + BIT_STEP);
      end
    end
  end

  // status-read arms the data write that clears the idle flag; set wins over clear
  // read then write sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_r <= 1'b0;
      idle_r <= 1'b1;
    end else if (clk_en) begin
      arm_r <= status_rd | (arm_r & ~data_wr);
      idle_r <= frame_done | ~serial_r | (idle_r & ~wr_accept);
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_idle_high;
    (state_r == TX_IDLE) |-> serial_output_pin == IDLE_LVL;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

  property p_start_low;
    (clk_en && load_go) |=> (serial_output_pin == START_LVL && in_shift);
  endproperty
  a_start_low: assert property (p_start_low) else $error("frame did not open low");

  property p_stop_pair;
    (in_shift && tx_path_on && bit_cnt_r >= 4'(frame_len_r - 4'h2)) |-> serial_output_pin;
  endproperty
  a_stop_pair: assert property (p_stop_pair) else $error("stop bit not high");

  property p_lsb_first;
    (clk_en && load_go) |=> shift_r[1] == $past(fifo_word[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit not word LSB");

  property p_flush;
    (clk_en && !serial_r) |=> (!fifo_out_valid && transmit_empty_flag);
  endproperty
  a_flush: assert property (p_flush) else $error("buffer kept words while off");

  property p_disable_bits;
    (clk_en && serial_r && ctrl_wr && !wr_serial_enable) |=>
      (!tx_en_r && !rx_en_r && !brk_r && rx_flags_clear) ##1 transmit_idle_flag;
  endproperty
  a_disable_bits: assert property (p_disable_bits) else $error("disable left bits set");

  property p_tx_stop;
    (clk_en && !tx_path_on) |=> (state_r == TX_IDLE && shift_r == FRAME_IDLE);
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("shifter ran without enable");

  property p_block;
    (data_wr && !transmit_empty_flag) |-> !wr_accept;
  endproperty
  a_block: assert property (p_block) else $error("write taken into full buffer");

  property p_idle_set;
    (clk_en && frame_done) |=> transmit_idle_flag && !in_shift || $past(load_go);
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle flag missed frame end");
endmodule // uart_format_enable_transmitter

// file: uart_tx_pkg.sv
/*
  Shared constants, codes and types of the serial port transmit path.
  Assumes the 9-bit word (eight data bits plus the ninth/parity slot) and 16-bit divider.
*/
package uart_tx_pkg;
  // widths and depths
  localparam int WORD_W = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_W = 12;
  localparam int BAUD_W = 16;

  // frame lengths in bit times: start + word + two stop bits
  localparam logic [3:0] FRAME_LEN_8 = 4'hB;
  localparam logic [3:0] FRAME_LEN_9 = 4'hC;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // line levels
  localparam logic [1:0] STOP_PAIR = 2'h3;
  localparam logic START_LVL = 1'b0;
  localparam logic IDLE_LVL = 1'b1;
  localparam logic [FRAME_W-1:0] FRAME_IDLE = 12'hFFF;

  // word field positions and masks of the bits covered by parity
  localparam int MSB_9 = WORD_W - 1;
  localparam int MSB_8 = WORD_W - 2;
  localparam logic [WORD_W-1:0] MASK_BELOW_9 = 9'h0FF;
  localparam logic [WORD_W-1:0] MASK_BELOW_8 = 9'h07F;

  // parity type select codes
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  // reset values: 8 data bits, no parity, one receive stop bit
  localparam logic RST_WORD_LEN = 1'b0;
  localparam logic RST_PARITY_EN = 1'b0;
  localparam logic [1:0] RST_PARITY_TYPE = PAR_EVEN;
  localparam logic RST_RX_STOP = 1'b0;
  localparam logic [BAUD_W-1:0] RST_BAUD_DIV = 16'h0010;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
endpackage
